// File: hw/strap_capture.sv
// Strap latch bank with its capture sequencer and weak pull control.
// Assumes rearm is high while any system reset source or chip disable is active.
`timescale 1ns/10ps
module strap_capture #(
  parameter int unsigned N         = 5,
  parameter logic [4:0]  PULL_UP   = 5'h1a,
  parameter logic [4:0]  FORCE_HI  = 5'h00
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         rearm,
  // Strap pins
  input  wire logic [N-1:0] strap_in,
  output logic      [N-1:0] pull_up_en,
  output logic      [N-1:0] pull_dn_en,
  // Captured values
  output logic      [N-1:0] held_r,
  output logic              capture_pulse,
  output logic              strap_role
);
  import strap_pkg::*;

  cap_state_e state_r;

  // Pins act as straps only until the capture edge after reset
  assign strap_role    = (state_r == ST_ARMED);
  assign capture_pulse = strap_role && !rearm;
  // Weak pulls only while in strap role, so a floating pin reads its default
  assign pull_up_en    = strap_role ? PULL_UP[N-1:0] : '0;
  assign pull_dn_en    = strap_role ? ~PULL_UP[N-1:0] : '0;

  // Sequencer: any reset source drops back to armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_ARMED;
    end else begin
      unique case (state_r)
        ST_ARMED: begin
          if (!rearm) begin
            state_r <= ST_HELD;
          end
        end
        ST_HELD: begin
          if (rearm) begin
            state_r <= ST_ARMED;
          end
        end
        default: state_r <= ST_ARMED;
      endcase
    end
  end

  // Latch once on release; later pin activity cannot reach held_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= '0;
    end else if (capture_pulse) begin
      held_r <= strap_in | FORCE_HI[N-1:0];
    end
  end
endmodule

// File: hw/strap_latch_top.sv
// Boot strap capture block: latches five straps at reset release, decodes
// supply, boot source, boot log and SDIO edge timing, APB register access.
// Assumes pclk is 40 MHz, strap pins are synchronous to pclk, and sys_reset_req
// gathers the power-on, watchdog and brownout reset sources.
// Function
// - Sample and latch five straps during reset
// - Latched bits hold until power down; here any reset source or chip disable re-latches them
// - Capture register returns five latched bits
// - Weak internal pulls applied during reset
// - Pull-down ldo, boot_b; pull-up others
// - Latched ldo 0 gives 3.3V, 1 1.8V
// - Boot_a 1 flash; both 0 download
// - Log strap 1 enables console boot log
// - Two straps select SDIO input/output edges
// - Firmware may override supply and SDIO timing
// - Straps become ordinary pins after reset
// - Module build forces ldo strap high
// - Chip-on input active high, low disables
`timescale 1ns/10ps
module strap_latch_top #(
  parameter bit MODULE_BUILD = 1'b1
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // System reset sources and chip enable
  input  wire logic                          sys_reset_req,
  input  wire logic                          chip_on_pin,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [strap_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Strap pins
  input  wire logic [strap_pkg::STRAP_N-1:0] strap_in,
  output logic      [strap_pkg::STRAP_N-1:0] pull_up_en,
  output logic      [strap_pkg::STRAP_N-1:0] pull_dn_en,
  output logic                               strap_role,
  // Decoded configuration
  output logic                               flash_io_1v8,
  output logic                               boot_download,
  output logic                               boot_sel_bad,
  output logic                               boot_log_en,
  output logic                               sdio_in_rising,
  output logic                               sdio_out_rising
);
  import strap_pkg::*;

  localparam logic [4:0] FORCE_MASK = MODULE_BUILD ? 5'h01 : 5'h00;

  logic [STRAP_N-1:0] strap_bits;
  logic               capture_pulse;
  logic               rearm;
  logic [OVR_W-1:0]   ovr_r;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic               flash_io_1v8_r;
  logic               boot_download_r;
  logic               boot_sel_bad_r;
  logic               boot_log_en_r;
  logic               sdio_in_rising_r;
  logic               sdio_out_rising_r;
  logic               setup_ph;
  logic               access_ph;
  logic               addr_ok;
  logic [31:0]        rd_word;

  // Chip disabled behaves like any other reset source
  assign rearm = sys_reset_req || !chip_on_pin;

  strap_capture #(
    .N        (STRAP_N),
    .PULL_UP  (PULL_UP_DEF),
    .FORCE_HI (FORCE_MASK)
  ) u_cap (
    .pclk          (pclk),
    .presetn       (presetn),
    .rearm         (rearm),
    .strap_in      (strap_in),
    .pull_up_en    (pull_up_en),
    .pull_dn_en    (pull_dn_en),
    .held_r        (strap_bits),
    .capture_pulse (capture_pulse),
    .strap_role    (strap_role)
  );

  // Register map decode, used by the error flag only; the read mux decodes paddr itself
  function automatic logic map_hit(input logic [ADDR_W-1:0] a);
    map_hit = (a == OFS_CAPTURE) || (a == OFS_OVERRIDE) || (a == OFS_STATUS);
  endfunction

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_ok   = map_hit(paddr);

  // Read mux; capture bits sit at fixed low positions
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFS_CAPTURE:  rd_word[STRAP_N-1:0] = strap_bits;
      OFS_OVERRIDE: rd_word[OVR_W-1:0]   = ovr_r;
      OFS_STATUS: begin
        rd_word[STS_HELD]     = !strap_role;
        rd_word[STS_DOWNLOAD] = boot_download_r;
        rd_word[STS_BOOT_BAD] = boot_sel_bad_r;
        rd_word[STS_1V8]      = flash_io_1v8_r;
        rd_word[STS_SDIO_IN]  = sdio_in_rising_r;
        rd_word[STS_SDIO_OUT] = sdio_out_rising_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data and error are registered in setup, so access never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_r <= !addr_ok;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r && access_ph;
  assign pready  = 1'b1;

  // Firmware override bits; take effect at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= OVR_RESET;
    end else if (access_ph && pwrite && (paddr == OFS_OVERRIDE)) begin
      ovr_r <= pwdata[OVR_W-1:0];
    end
  end

  // Supply select: override wins once firmware enables it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_io_1v8_r <= 1'b0;
    end else begin
      flash_io_1v8_r <= ovr_r[OVR_LDO_EN] ? ovr_r[OVR_LDO_1V8]
                                          : strap_bits[BIT_LDO];
    end
  end

  // Boot source; a=0,b=1 is not a defined mode and is flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_download_r <= 1'b0;
      boot_sel_bad_r  <= 1'b0;
    end else begin
      boot_download_r <= !strap_bits[BIT_BOOT_A] && !strap_bits[BIT_BOOT_B];
      boot_sel_bad_r  <= !strap_bits[BIT_BOOT_A] && strap_bits[BIT_BOOT_B];
    end
  end

  // Boot log enable gates console output during boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_log_en_r <= 1'b0;
    end else begin
      boot_log_en_r <= strap_bits[BIT_LOG_TIME];
    end
  end

  // SDIO edges: first strap picks input edge, second output edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdio_in_rising_r  <= 1'b0;
      sdio_out_rising_r <= 1'b0;
    end else if (ovr_r[OVR_SDIO_EN]) begin
      sdio_in_rising_r  <= ovr_r[OVR_SDIO_IN];
      sdio_out_rising_r <= ovr_r[OVR_SDIO_OUT];
    end else begin
      sdio_in_rising_r  <= strap_bits[BIT_LOG_TIME];
      sdio_out_rising_r <= strap_bits[BIT_SDIO_EDGE];
    end
  end

  assign flash_io_1v8    = flash_io_1v8_r;
  assign boot_download   = boot_download_r;
  assign boot_sel_bad    = boot_sel_bad_r;
  assign boot_log_en     = boot_log_en_r;
  assign sdio_in_rising  = sdio_in_rising_r;
  assign sdio_out_rising = sdio_out_rising_r;

  // Checks
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      capture_pulse |=> strap_bits == ($past(strap_in) | FORCE_MASK);
  endproperty
  a_capture: assert property (p_capture) else $error("strap capture mismatch");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !strap_role ##1 !strap_role |-> $stable(strap_bits);
  endproperty
  a_hold: assert property (p_hold) else $error("held straps changed");

  property p_read_cap;
    @(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && paddr == OFS_CAPTURE && !capture_pulse)
        ##1 access_ph |-> prdata[STRAP_N-1:0] == strap_bits && prdata[31:STRAP_N] == '0;
  endproperty
  a_read_cap: assert property (p_read_cap) else $error("capture read wrong");

  property p_pulls;
    @(posedge pclk) disable iff (!presetn)
      strap_role |-> pull_up_en == PULL_UP_DEF && pull_dn_en == ~PULL_UP_DEF;
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull defaults wrong");

  property p_ldo;
    @(posedge pclk) disable iff (!presetn)
      (!ovr_r[OVR_LDO_EN] && !strap_role) ##1 !strap_role
        |-> flash_io_1v8 == $past(strap_bits[BIT_LDO]);
  endproperty
  a_ldo: assert property (p_ldo) else $error("supply select wrong");

  property p_boot;
    @(posedge pclk) disable iff (!presetn)
      !strap_bits[BIT_BOOT_A] && !strap_bits[BIT_BOOT_B] |=> boot_download;
  endproperty
  a_boot: assert property (p_boot) else $error("download boot missed");

  property p_log;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> boot_log_en == $past(strap_bits[BIT_LOG_TIME]);
  endproperty
  a_log: assert property (p_log) else $error("boot log enable wrong");

  property p_sdio;
    @(posedge pclk) disable iff (!presetn)
      !ovr_r[OVR_SDIO_EN] |=> sdio_in_rising == $past(strap_bits[BIT_LOG_TIME])
        && sdio_out_rising == $past(strap_bits[BIT_SDIO_EDGE]);
  endproperty
  a_sdio: assert property (p_sdio) else $error("sdio timing wrong");

  property p_ovr;
    @(posedge pclk) disable iff (!presetn)
      access_ph && pwrite && paddr == OFS_OVERRIDE ##1 ovr_r[OVR_SDIO_EN]
        |=> sdio_in_rising == $past(ovr_r[OVR_SDIO_IN]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not applied");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      capture_pulse |=> !strap_role && pull_up_en == '0 && pull_dn_en == '0;
  endproperty
  a_release: assert property (p_release) else $error("strap role not released");

  property p_chip_off;
    @(posedge pclk) disable iff (!presetn)
      !chip_on_pin |=> strap_role;
  endproperty
  a_chip_off: assert property (p_chip_off) else $error("chip disable ignored");

  property p_module_ldo;
    @(posedge pclk) disable iff (!presetn)
      MODULE_BUILD && capture_pulse |=> strap_bits[BIT_LDO];
  endproperty
  a_module_ldo: assert property (p_module_ldo) else $error("module ldo not high");

  property p_boot_bad;
    @(posedge pclk) disable iff (!presetn)
      !strap_bits[BIT_BOOT_A] && strap_bits[BIT_BOOT_B] |=> boot_sel_bad && !boot_download;
  endproperty
  a_boot_bad: assert property (p_boot_bad) else $error("undefined boot select missed");

  // Boot_a high means flash boot whatever boot_b says
  property p_boot_flash;
    @(posedge pclk) disable iff (!presetn)
      strap_bits[BIT_BOOT_A] |=> !boot_download && !boot_sel_bad;
  endproperty
  a_boot_flash: assert property (p_boot_flash) else $error("flash boot not selected");

  property p_ovr_ldo;
    @(posedge pclk) disable iff (!presetn)
      ovr_r[OVR_LDO_EN] |=> flash_io_1v8 == $past(ovr_r[OVR_LDO_1V8]);
  endproperty
  a_ovr_ldo: assert property (p_ovr_ldo) else $error("supply override not applied");

  property p_ovr_sdio;
    @(posedge pclk) disable iff (!presetn)
      ovr_r[OVR_SDIO_EN] |=> sdio_in_rising == $past(ovr_r[OVR_SDIO_IN])
        && sdio_out_rising == $past(ovr_r[OVR_SDIO_OUT]);
  endproperty
  a_ovr_sdio: assert property (p_ovr_sdio) else $error("sdio override not applied");

  property p_cov_download;
    @(posedge pclk) disable iff (!presetn) capture_pulse ##1 boot_download;
  endproperty
  c_cov_download: cover property (p_cov_download);

  property p_cov_ovr;
    @(posedge pclk) disable iff (!presetn) access_ph && pwrite && paddr == OFS_OVERRIDE;
  endproperty
  c_cov_ovr: cover property (p_cov_ovr);

  property p_cov_recap;
    @(posedge pclk) disable iff (!presetn) !strap_role ##1 strap_role ##[1:20] capture_pulse;
  endproperty
  c_cov_recap: cover property (p_cov_recap);

  property p_cov_chip_off;
    @(posedge pclk) disable iff (!presetn) !strap_role ##1 !chip_on_pin ##1 strap_role;
  endproperty
  c_cov_chip_off: cover property (p_cov_chip_off);
endmodule

// File: hw/strap_pkg.sv
// Shared constants for the boot strap capture block.
// Assumes a 32-bit APB register bus and five strap inputs.
package strap_pkg;
  localparam int unsigned   STRAP_N       = 5;
  localparam int unsigned   ADDR_W        = 12;
  // Register byte offsets
  localparam logic [11:0]   OFS_CAPTURE   = 12'h000;
  localparam logic [11:0]   OFS_OVERRIDE  = 12'h004;
  localparam logic [11:0]   OFS_STATUS    = 12'h008;
  // Strap bit positions in the capture register
  localparam int unsigned   BIT_LDO       = 0;
  localparam int unsigned   BIT_BOOT_A    = 1;
  localparam int unsigned   BIT_BOOT_B    = 2;
  localparam int unsigned   BIT_LOG_TIME  = 3;
  localparam int unsigned   BIT_SDIO_EDGE = 4;
  // Default pull per strap: 1 = pull-up, 0 = pull-down
  localparam logic [4:0]    PULL_UP_DEF   = 5'h1a;
  // Override register fields
  localparam int unsigned   OVR_LDO_EN    = 0;
  localparam int unsigned   OVR_LDO_1V8   = 1;
  localparam int unsigned   OVR_SDIO_EN   = 2;
  localparam int unsigned   OVR_SDIO_IN   = 3;
  localparam int unsigned   OVR_SDIO_OUT  = 4;
  localparam int unsigned   OVR_W         = 5;
  localparam logic [4:0]    OVR_RESET     = 5'h00;
  // Status register fields
  localparam int unsigned   STS_HELD      = 0;
  localparam int unsigned   STS_DOWNLOAD  = 1;
  localparam int unsigned   STS_BOOT_BAD  = 2;
  localparam int unsigned   STS_1V8       = 3;
  localparam int unsigned   STS_SDIO_IN   = 4;
  localparam int unsigned   STS_SDIO_OUT  = 5;
  // Capture sequencer states
  typedef enum logic [1:0] {
    ST_ARMED = 2'b01,
    ST_HELD  = 2'b10
  } cap_state_e;
endpackage

// File: verification/strap_host_model.sv
// Board side of the strap pins: host GPIO drivers and otherwise floating lines.
// Assumes drive_en/drive_val come from the bench and pull enables from the device.
`timescale 1ns/10ps
module strap_host_model (
  // Device pull control
  input  wire logic [4:0] pull_up_en,
  input  wire logic [4:0] pull_dn_en,
  // Bench control of the host drivers
  input  wire logic [4:0] drive_en,
  input  wire logic [4:0] drive_val,
  // Resolved pin levels
  output logic      [4:0] strap_in
);
  logic [4:0] lvl = 5'h00;

  // A line with no driver and no pull flips, so a stale level never passes for a capture
  always @(drive_en or drive_val or pull_up_en or pull_dn_en) begin
    for (int i = 0; i < 5; i++) begin
      if (drive_en[i])
        lvl[i] = drive_val[i];
      else if (pull_up_en[i])
        lvl[i] = 1'b1;
      else if (pull_dn_en[i])
        lvl[i] = 1'b0;
      else
        lvl[i] = ~lvl[i];
    end
  end
  assign strap_in = lvl;
endmodule

// File: verification/tb_reset_strap_latch.sv
// Self-checking bench for the strap capture block with an APB master.
// Assumes the host model resolves the strap pins from bench drive and device pulls.
`timescale 1ns/10ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_reset_strap_latch;
  import strap_pkg::*;
  localparam bit MB = 1'b1;
  logic              pclk = 1'b0, presetn = 1'b0, sys_reset_req = 1'b0, chip_on_pin = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, err, strap_role;
  logic [4:0]        strap_in, pull_up_en, pull_dn_en, drv_en = '0, drv_val = '0, exp_s;
  logic              flash_io_1v8, boot_download, boot_sel_bad, boot_log_en;
  logic              sdio_in_rising, sdio_out_rising;
  int                error_cnt = 0, checked = 0, cycles = 0, ovr = 0;

  strap_latch_top #(.MODULE_BUILD(MB)) dut (
    .pclk(pclk), .presetn(presetn), .sys_reset_req(sys_reset_req), .chip_on_pin(chip_on_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_in(strap_in),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .strap_role(strap_role),
    .flash_io_1v8(flash_io_1v8), .boot_download(boot_download), .boot_sel_bad(boot_sel_bad),
    .boot_log_en(boot_log_en), .sdio_in_rising(sdio_in_rising),
    .sdio_out_rising(sdio_out_rising));

  strap_host_model host (.pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .drive_en(drv_en), .drive_val(drv_val), .strap_in(strap_in));

  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard, far above the roughly 600 cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
    end
  end

  task give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high at an edge.
  // No wait limit of its own: a stuck bus is ended by the hang guard.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] d, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Reference decode of the held straps and override, compared at pins and registers
  task check_cfg();
    logic v18, sin, sout, dl, bad;
    v18  = ovr[OVR_LDO_EN] ? ovr[OVR_LDO_1V8] : exp_s[BIT_LDO];
    sin  = ovr[OVR_SDIO_EN] ? ovr[OVR_SDIO_IN] : exp_s[BIT_LOG_TIME];
    sout = ovr[OVR_SDIO_EN] ? ovr[OVR_SDIO_OUT] : exp_s[BIT_SDIO_EDGE];
    dl   = ~exp_s[BIT_BOOT_A] & ~exp_s[BIT_BOOT_B];
    bad  = ~exp_s[BIT_BOOT_A] & exp_s[BIT_BOOT_B];
    `CHK(flash_io_1v8, v18, "supply select")
    `CHK({boot_download, boot_sel_bad}, {dl, bad}, "boot source")
    `CHK(boot_log_en, exp_s[BIT_LOG_TIME], "boot log enable")
    `CHK({sdio_in_rising, sdio_out_rising}, {sin, sout}, "sdio edges")
    apb(1'b0, OFS_CAPTURE, $urandom, rd, err);
    `CHK(rd, {27'h0, exp_s}, "capture register")
    apb(1'b0, OFS_STATUS, $urandom, rd, err);
    `CHK(rd, {26'h0, sout, sin, v18, bad, dl, 1'b1}, "status register")
  endtask

  // Re-arm by a reset source or chip disable; pins change at the release edge itself
  task recapture(input logic [4:0] en, input logic [4:0] val, input bit via_chip);
    if (via_chip)
      chip_on_pin <= 1'b0;
    else
      sys_reset_req <= 1'b1;
    drv_en  <= en;
    drv_val <= ~val;
    repeat (3) @(posedge pclk);
    `CHK(strap_role, 1'b1, "armed during reset")
    `CHK({pull_up_en, pull_dn_en}, {PULL_UP_DEF, ~PULL_UP_DEF}, "pulls in reset")
    chip_on_pin   <= 1'b1;
    sys_reset_req <= 1'b0;
    drv_val       <= val;
    repeat (3) @(posedge pclk);
    exp_s = (en & val) | (~en & PULL_UP_DEF);
    exp_s[BIT_LDO] = exp_s[BIT_LDO] | MB;
    `CHK(strap_role, 1'b0, "strap role released")
    `CHK({pull_up_en, pull_dn_en}, 10'h000, "pulls off")
  endtask

  initial begin
    void'($urandom(32'h58a5b87a));
    repeat (10) @(posedge pclk);
    `CHK({strap_role, pull_up_en, pull_dn_en}, {1'b1, PULL_UP_DEF, ~PULL_UP_DEF}, "reset")
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    exp_s = PULL_UP_DEF | {4'h0, MB};
    check_cfg();
    $display("floating defaults test done");
    // All 32 drive values, the upper 16 part floating, then pin noise after the capture
    for (int i = 0; i < 32; i++) begin
      recapture(i < 16 ? 5'h1f : 5'($urandom), i[4:0], 1'($urandom));
      drv_en <= 5'h1f;
      drv_val <= 5'($urandom);
      repeat (2) @(posedge pclk);
      check_cfg();
    end
    $display("strap capture test done");
    // Firmware overrides; the read-only capture register refuses writes, unmapped reads flag an error
    for (int k = 0; k < 8; k++) begin
      ovr = $urandom_range(31);
      apb(1'b1, OFS_OVERRIDE, {27'($urandom), 5'(ovr)}, rd, err);
      apb(1'b1, OFS_CAPTURE, $urandom, rd, err);
      apb(1'b0, OFS_OVERRIDE, $urandom, rd, err);
      `CHK({err, rd}, {1'b0, 32'(ovr)}, "override readback")
      apb(1'b0, 12'h00c, $urandom, rd, err);
      `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
      check_cfg();
    end
    $display("override test done");
    give_verdict();
  end
endmodule
